// ---- verilog/ctm_map.svh ----
`ifndef CTM_MAP_SVH
`define CTM_MAP_SVH
// Contract
// - Fast ch1 is 0-60 kV, ch2 0-500 A.
// - Receivers polled, sender sets packet timing.
// - Update buffers only on complete valid packet.
// - Fast fault or timeout zeroes buffers, sets flag.
// - Multi fault or timeout zeroes channels, sets flag.
// - Model reads latest stored values, never waits.
// - Model temperature to muxed DAC each update.
// - Echo fast channels to DAC per packet.
// - Echo rescaled outlet temperatures per pair 0 or 1 multi packet.
// - RF power cubic in unsigned 32-bit math.
// - Diode count full scale is 2.456 V.
// - Coefficients c1-c4 loadable per tube, defaults kept.
// - Add k-weighted power increment every 1 ms.
// - 64-bit accumulate, keep upper 32 bits.
// - Current local, voltage fast, flow/inlet multi.
// - Model iterates always, ignores shot state.
// - Latch tube fault when temperature exceeds threshold.
// - Fault clears on reset command once cool.
// - Link fault on timeout, checksum or format error.
// - Threshold refreshed on every model update.

// Clock and timing figures.
`define CTM_CLK_HZ        20000000
`define CTM_STEP_HZ       4000
`define CTM_LINK_TMO_US   1000
// Coefficient defaults.
`define CTM_C1_DEF        32'h0000_00e2
`define CTM_C2_DEF        32'h0000_1518
// Multi-link channel map: outlet temps, flows, pressures, inlet temp.
`define CTM_CH_TOUT       0
`define CTM_CH_FLOW       4
`define CTM_CH_TIN        12
// DAC channel map.
`define CTM_DAC_MODEL     0
`define CTM_DAC_VOLT      4
`define CTM_DAC_CURR      5
`define CTM_DAC_TOUT      6
// Loader selectors: 0-3 are c1-c4, 4-7 are k1-k4.
`define CTM_SEL_K         4
// Scale shifts in the RF power fit.
`define CTM_CUBE_SH       6
`define CTM_SQ_SH         4
`define CTM_DAC_MAX       12'hfff
`define CTM_OUT_SH        12
`endif

// ---- verilog/ctm_pkg.sv ----
package ctm_pkg;
    typedef logic [11:0] ctm_word_type;
    // Decoded fast-link packet from the fibre front end.
    typedef struct packed {
        logic         stb;
        logic         err;
        ctm_word_type ch1;
        ctm_word_type ch2;
    } ctm_fast_type;
    // Decoded multi-channel packet: a channel pair and its pair index.
    typedef struct packed {
        logic         stb;
        logic         err;
        logic [2:0]   pair;
        ctm_word_type d0;
        ctm_word_type d1;
    } ctm_multi_type;
    // Coefficient loader request.
    typedef struct packed {
        logic         stb;
        logic [1:0]   tube;
        logic [2:0]   sel;
        logic [31:0]  data;
    } ctm_cfg_type;
    // Whole state of the model block.
    typedef struct packed {
        ctm_word_type [1:0]        fast;
        logic                      fast_flt;
        logic [15:0]               fast_to;
        ctm_word_type [15:0]       mch;
        logic                      mc_flt;
        logic [15:0]               mc_to;
        logic [15:0]               tick;
        logic [1:0]                tube;
        logic [3:0][31:0]          temp;
        ctm_word_type [3:0]        thr;
        logic [3:0]                latch;
        logic [3:0]                ok;
        logic                      master;
        logic [3:0][3:0][31:0]     c;
        logic [3:0][31:0]          k;
        logic [9:0]                pend;
        ctm_word_type              dac_code;
        logic [3:0]                dac_sel;
        logic                      dac_load;
    } ctm_state_type;
endpackage

// ---- verilog/ctm_top.sv ----
`timescale 1ns/1ps
`include "ctm_map.svh"
module ctm_top
    import ctm_pkg::*;
#(
    parameter int STEP_CYC = `CTM_CLK_HZ / `CTM_STEP_HZ,                       // Cycles per tube step.
    parameter int TMO_CYC  = `CTM_CLK_HZ / 1000000 * `CTM_LINK_TMO_US,         // Link timeout.
    parameter logic [31:0] C3_DEF = 32'h0000_0000,                            // Default c3.
    parameter logic [31:0] C4_DEF = 32'h0000_0000,                            // Default c4.
    parameter logic [31:0] K_DEF  = 32'h0000_0000,                            // Default k1-k4.
    parameter logic [11:0] TOUT_SCALE = 12'hfff                               // Outlet rescale / 4096.
) (
    input  wire logic               clock,       // System clock, 20 MHz.
    input  wire logic               rst_b,       // Asynchronous reset, active low.
    input  wire ctm_fast_type       fast_pkt,    // Fast-link decoded packet.
    input  wire ctm_multi_type      multi_pkt,   // Multi-link decoded packet.
    input  wire ctm_cfg_type        cfg,         // Coefficient loader.
    input  wire ctm_word_type [3:0] beam_i,      // Local beam current counts.
    input  wire ctm_word_type [3:0] fwd_n,       // Forward diode counts.
    input  wire ctm_word_type [3:0] thr_in,      // Fault thresholds per tube.
    input  wire logic               fault_reset, // Reset command from controller.
    output logic [3:0]              tube_ok,     // Tube temperature good flags.
    output logic                    master_model_fault, // Master fault, high when bad.
    output logic                    fast_link_fault,    // Fast link error flag.
    output logic                    multi_link_fault,   // Multi link error flag.
    output ctm_word_type            dac_code,    // Muxed DAC code.
    output logic [3:0]              dac_sel,     // Muxed DAC channel.
    output logic                    dac_load     // DAC load strobe.
);
    ////////////////////////////////////////////////////////////////////////////////
    ctm_state_type s_r;                 // Registered state.
    ctm_state_type s_nxt;               // Next state.
    logic [31:0]   n_c;                 // Forward count, 32 bits.
    logic [31:0]   n64_c;               // Count scaled for the cube term.
    logic [31:0]   n16_c;               // Count scaled for the square term.
    logic [31:0]   prf_c;               // Calibrated RF power in mW.
    logic signed [63:0] acc_c;          // Increment accumulator.
    logic signed [31:0] tnew_c;         // Updated model temperature.
    logic [31:0]   flow_c;              // Flow of the current tube.
    logic [31:0]   tin_c;               // Inlet temperature.
    logic [31:0]   volt_c;              // Beam voltage counts.
    logic [31:0]   cur_c;               // Beam current counts.
    logic [23:0]   tout_c;              // Rescaled outlet product.
    logic [3:0]    idx_c;               // DAC channel chosen this cycle.
    logic          over_c;              // Current tube above threshold.
    logic          fast_ok_c;           // Valid fast packet this cycle.
    logic          mc_ok_c;             // Valid multi packet this cycle.

    assign tube_ok            = s_r.ok;
    assign master_model_fault = s_r.master;
    assign fast_link_fault    = s_r.fast_flt;
    assign multi_link_fault   = s_r.mc_flt;
    assign dac_code           = s_r.dac_code;
    assign dac_sel            = s_r.dac_sel;
    assign dac_load           = s_r.dac_load;

    ////////////////////////////////////////////////////////////////////////////////
    // Clamp a signed model temperature into DAC code range.
    function automatic ctm_word_type clamp12(input logic signed [31:0] t);
        ctm_word_type r;
        if (t < 0) begin
            r = 12'h000;
        end else if (t > $signed({20'h00000, `CTM_DAC_MAX})) begin
            r = `CTM_DAC_MAX;
        end else begin
            r = t[11:0];
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Next-state logic: link buffers, model step, fault latches and DAC mux.
    always_comb begin
        s_nxt = s_r;
        s_nxt.dac_load = 1'b0;
        // The fast packet counts only when complete and error free.
        fast_ok_c = fast_pkt.stb & ~fast_pkt.err;
        mc_ok_c   = multi_pkt.stb & ~multi_pkt.err;

        // Fast link: polled, so a timeout counter tracks sender silence.
        if (fast_ok_c) begin
            s_nxt.fast[0]  = fast_pkt.ch1;
            s_nxt.fast[1]  = fast_pkt.ch2;
            s_nxt.fast_flt = 1'b0;
            s_nxt.fast_to  = 16'h0000;
            s_nxt.pend[`CTM_DAC_VOLT] = 1'b1;
            s_nxt.pend[`CTM_DAC_CURR] = 1'b1;
        end else if (fast_pkt.stb || s_r.fast_to == 16'(TMO_CYC - 1)) begin
            s_nxt.fast     = '0;
            s_nxt.fast_flt = 1'b1;
            s_nxt.fast_to  = 16'h0000;
        end else begin
            s_nxt.fast_to  = s_r.fast_to + 16'h0001;
        end

        // Multi link: each packet carries one channel pair.
        if (mc_ok_c) begin
            s_nxt.mch[{multi_pkt.pair, 1'b0}] = multi_pkt.d0;
            s_nxt.mch[{multi_pkt.pair, 1'b1}] = multi_pkt.d1;
            s_nxt.mc_flt = 1'b0;
            s_nxt.mc_to  = 16'h0000;
            // Outlet temperatures sit in channels 0-3, pairs 0 and 1.
            if (multi_pkt.pair[2:1] == 2'b00) begin
                s_nxt.pend[`CTM_DAC_TOUT + {multi_pkt.pair[0], 1'b0}] = 1'b1;
                s_nxt.pend[`CTM_DAC_TOUT + {multi_pkt.pair[0], 1'b1}] = 1'b1;
            end
        end else if (multi_pkt.stb || s_r.mc_to == 16'(TMO_CYC - 1)) begin
            s_nxt.mch    = '0;
            s_nxt.mc_flt = 1'b1;
            s_nxt.mc_to  = 16'h0000;
        end else begin
            s_nxt.mc_to  = s_r.mc_to + 16'h0001;
        end

        // Coefficient loads may arrive at any time and apply at once.
        if (cfg.stb) begin
            if (cfg.sel[2]) begin
                s_nxt.k[cfg.sel[1:0]] = cfg.data;
            end else begin
                s_nxt.c[cfg.tube][cfg.sel[1:0]] = cfg.data;
            end
        end

        // RF power for the tube in turn; intermediates wrap in 32 bits.
        n_c   = {20'h00000, fwd_n[s_r.tube]};
        n64_c = n_c >> `CTM_CUBE_SH;
        n16_c = n_c >> `CTM_SQ_SH;
        prf_c = 32'(s_r.c[s_r.tube][1] * n16_c * n16_c) + s_r.c[s_r.tube][3]
              - 32'(s_r.c[s_r.tube][0] * n64_c * n64_c * n64_c)
              - 32'(s_r.c[s_r.tube][2] * n_c);

        // Link inputs come straight from the stored buffers, current straight from beam_i, without waiting.
        volt_c = {20'h00000, s_r.fast[0]};
        cur_c  = {20'h00000, beam_i[s_r.tube]};
        flow_c = {20'h00000, s_r.mch[`CTM_CH_FLOW + 32'(s_r.tube)]};
        tin_c  = {20'h00000, s_r.mch[`CTM_CH_TIN]};
        acc_c  = $signed({32'h0, s_r.k[0]}) * $signed({32'h0, volt_c * cur_c})
               + $signed({32'h0, s_r.k[1]}) * $signed({32'h0, flow_c * tin_c})
               - $signed({32'h0, s_r.k[2]}) * $signed({32'h0, prf_c})
               - $signed({32'h0, s_r.k[3]}) * $signed(64'(flow_c)) *
                 $signed(64'($signed(s_r.temp[s_r.tube])));
        tnew_c = $signed(s_r.temp[s_r.tube]) + $signed(acc_c[63:32]);
        over_c = tnew_c > $signed({20'h00000, thr_in[s_r.tube]});

        // Step timer runs free: one tube per quarter millisecond.
        if (s_r.tick == 16'(STEP_CYC - 1)) begin
            s_nxt.tick = 16'h0000;
            s_nxt.tube = s_r.tube + 2'b01;
            s_nxt.temp[s_r.tube] = tnew_c;
            s_nxt.thr[s_r.tube]  = thr_in[s_r.tube];
            s_nxt.pend[`CTM_DAC_MODEL + 32'(s_r.tube)] = 1'b1;
            if (over_c) begin
                s_nxt.latch[s_r.tube] = 1'b1;
            end else if (fault_reset) begin
                s_nxt.latch[s_r.tube] = 1'b0;
            end
        end else begin
            s_nxt.tick = s_r.tick + 16'h0001;
        end
        // A reset command clears other cool tubes; a fresh trip wins.
        for (int t = 0; t < 4; t++) begin
            if (fault_reset && !(s_nxt.latch[t] && t == 32'(s_r.tube) &&
                s_r.tick == 16'(STEP_CYC - 1)) &&
                $signed(s_r.temp[t]) <= $signed({20'h00000, s_r.thr[t]})) begin
                s_nxt.latch[t] = 1'b0;
            end
        end

        // Link faults drop the flags without latching.
        s_nxt.ok[0] = ~s_nxt.latch[0] & ~s_nxt.fast_flt;
        s_nxt.ok[1] = ~s_nxt.latch[1] & ~s_nxt.fast_flt;
        s_nxt.ok[2] = ~s_nxt.latch[2] & ~s_nxt.mc_flt;
        s_nxt.ok[3] = ~s_nxt.latch[3] & ~s_nxt.mc_flt;
        s_nxt.master = (|s_nxt.latch) | s_nxt.fast_flt | s_nxt.mc_flt;

        // DAC mux: lowest pending channel goes out, one per cycle.
        idx_c  = 4'h0;
        tout_c = 24'h000000;
        for (int i = 9; i >= 0; i--) begin
            if (s_r.pend[i]) begin
                idx_c = 4'(i);
            end
        end
        if (|s_r.pend) begin
            s_nxt.pend[idx_c] = 1'b0;
            s_nxt.dac_sel     = idx_c;
            s_nxt.dac_load    = 1'b1;
            if (idx_c < 4'(`CTM_DAC_VOLT)) begin
                s_nxt.dac_code = clamp12($signed(s_r.temp[idx_c[1:0]]));
            end else if (idx_c < 4'(`CTM_DAC_TOUT)) begin
                s_nxt.dac_code = s_r.fast[idx_c[0]];
            end else begin
                tout_c = s_r.mch[`CTM_CH_TOUT + 32'(idx_c - 4'(`CTM_DAC_TOUT))] *
                         TOUT_SCALE;
                s_nxt.dac_code = tout_c[23:12];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // State register; coefficient defaults load at reset.
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            s_r        <= '0;
            s_r.fast_flt <= 1'b1;
            s_r.mc_flt <= 1'b1;
            s_r.master <= 1'b1;
            for (int t = 0; t < 4; t++) begin
                s_r.c[t][0] <= `CTM_C1_DEF;
                s_r.c[t][1] <= `CTM_C2_DEF;
                s_r.c[t][2] <= C3_DEF;
                s_r.c[t][3] <= C4_DEF;
                s_r.k[t]    <= K_DEF;
            end
        end else begin
            s_r <= s_nxt;
        end
    end
endmodule

// ---- sim/ctm_props.sv ----
`timescale 1ns/1ps
module ctm_props_chk
    import ctm_pkg::*;
#(
    parameter int STEP_CYC = 50, // Cycles per tube step.
    parameter int TMO_CYC  = 400 // Link timeout in cycles.
) (
    input wire logic          clock,              // System clock.
    input wire logic          rst_b,              // Reset, active low.
    input wire ctm_fast_type  fast_pkt,           // Fast link packet.
    input wire ctm_multi_type multi_pkt,          // Multi link packet.
    input wire logic [3:0]    tube_ok,            // Tube good flags.
    input wire logic          master_model_fault, // Master fault.
    input wire logic          fast_link_fault,    // Fast link fault.
    input wire logic          multi_link_fault,   // Multi link fault.
    input wire ctm_word_type  dac_code,           // DAC code.
    input wire logic [3:0]    dac_sel,            // DAC channel.
    input wire logic          dac_load            // DAC strobe.
);
    logic [15:0]  idle_r; // Cycles since the last fast packet.
    logic [15:0]  gap_r;  // Cycles since the last model DAC load.
    ctm_word_type volt_r; // Voltage of the last good fast packet.
    // Helper counters; they saturate so a long idle never wraps to zero.
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            idle_r <= 16'h0000;
            gap_r  <= 16'h0000;
            volt_r <= 12'h000;
        end else begin
            idle_r <= fast_pkt.stb ? 16'h0000 : idle_r + 16'((idle_r != 16'hffff));
            gap_r  <= (dac_load && dac_sel < 4'h4) ? 16'h0000 : gap_r + 16'((gap_r != 16'hffff));
            volt_r <= (fast_pkt.stb && !fast_pkt.err) ? fast_pkt.ch1 : volt_r;
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    sequence seq_fast_good;
        fast_pkt.stb && !fast_pkt.err;
    endsequence
    sequence seq_volt_echo;
        dac_load && dac_sel == 4'h4 && dac_code == volt_r;
    endsequence
    AST_FAST_GOOD: assert property (seq_fast_good |-> ##2 !fast_link_fault)
        else $error("fast link still faulted after a good packet");
    AST_FAST_ERR: assert property (fast_pkt.stb && fast_pkt.err |-> ##2 fast_link_fault)
        else $error("fast link error not flagged");
    AST_MULTI_GOOD: assert property (multi_pkt.stb && !multi_pkt.err |-> ##2 !multi_link_fault)
        else $error("multi link still faulted after a good packet");
    AST_MULTI_ERR: assert property (multi_pkt.stb && multi_pkt.err |-> ##2 multi_link_fault)
        else $error("multi link error not flagged");
    AST_VOLT_ECHO: assert property (seq_fast_good ##1 1'b1 |-> ##[1:40] seq_volt_echo)
        else $error("voltage echo missing on the DAC");
    AST_LINK_TIMEOUT: assert property (idle_r > 16'(TMO_CYC + 2) |-> fast_link_fault)
        else $error("fast link timeout not flagged");
    AST_FAST_TUBES: assert property (fast_link_fault && $past(fast_link_fault)
        |-> tube_ok[1:0] == 2'b00 && master_model_fault)
        else $error("tubes 0 and 1 good while fast link faulted");
    AST_MULTI_TUBES: assert property (multi_link_fault && $past(multi_link_fault)
        |-> tube_ok[3:2] == 2'b00 && master_model_fault)
        else $error("tubes 2 and 3 good while multi link faulted");
    AST_MODEL_RATE: assert property (gap_r <= 16'(STEP_CYC + 16))
        else $error("model DAC update overdue");
endmodule
bind ctm_top ctm_props_chk #(.STEP_CYC(STEP_CYC), .TMO_CYC(TMO_CYC)) u_props (
    .clock(clock), .rst_b(rst_b), .fast_pkt(fast_pkt), .multi_pkt(multi_pkt),
    .tube_ok(tube_ok), .master_model_fault(master_model_fault),
    .fast_link_fault(fast_link_fault), .multi_link_fault(multi_link_fault),
    .dac_code(dac_code), .dac_sel(dac_sel), .dac_load(dac_load));

// ---- sim/ctm_link_model.sv ----
`timescale 1ns/1ps
module ctm_link_model
    import ctm_pkg::*;
(
    input  wire logic    clock,    // System clock.
    output ctm_fast_type  fast_pkt, // Fast sender packets.
    output ctm_multi_type multi_pkt // Multi sender packets.
);
    initial begin
        fast_pkt  = '0;
        multi_pkt = '0;
    end
    // Fast sender: voltage and current in one packet, timing set by the sender.
    task automatic send_fast(input ctm_word_type v, input ctm_word_type i, input logic bad);
        @(negedge clock);
        fast_pkt = {1'b1, bad, v, i};
        @(negedge clock);
        fast_pkt = {1'b0, 1'b0, ~v, ~i}; // Released data is garbage, not the old value.
    endtask
    // Multi sender: two channels of sixteen per packet.
    task automatic send_multi(input logic [2:0] p, input ctm_word_type a, input ctm_word_type b,
                              input logic bad);
        @(negedge clock);
        multi_pkt = {1'b1, bad, p, a, b};
        @(negedge clock);
        multi_pkt = {1'b0, 1'b0, ~p, ~a, ~b};
    endtask
endmodule

// ---- sim/tb_collector_temperature_model.sv ----
`timescale 1ns/1ps
module tb_collector_temperature_model
    import ctm_pkg::*;
;
    localparam int STEP = 50;   // Short tube step to keep the run brief.
    localparam int TMO  = 4000; // Timeout long enough to outlast a model round.
    typedef struct packed {logic multi; logic bad; ctm_word_type a; ctm_word_type b;} ctm_row_type;
    logic               clock, rst_b, fault_reset, master_model_fault;
    logic               fast_link_fault, multi_link_fault, dac_load;
    logic [3:0]         tube_ok, dac_sel;
    ctm_fast_type       fast_pkt;
    ctm_multi_type      multi_pkt;
    ctm_cfg_type        cfg;
    ctm_word_type [3:0] beam_i, fwd_n, thr_in;
    ctm_word_type       dac_code, m0, m1;
    int                 errors, total_checks, cycles;
    ctm_row_type rows [6] = '{'{0, 0, 12'h123, 12'h0ab}, '{0, 0, 12'hfff, 12'h000},
        '{0, 1, 12'h555, 12'h555}, '{1, 0, 12'h800, 12'hfff}, '{1, 0, 12'h001, 12'h7ff},
        '{1, 1, 12'h555, 12'h555}};
    ctm_link_model u_link (.clock(clock), .fast_pkt(fast_pkt), .multi_pkt(multi_pkt));
    ctm_top #(.STEP_CYC(STEP), .TMO_CYC(TMO)) u_dut (
        .clock(clock), .rst_b(rst_b), .fast_pkt(fast_pkt), .multi_pkt(multi_pkt), .cfg(cfg),
        .beam_i(beam_i), .fwd_n(fwd_n), .thr_in(thr_in), .fault_reset(fault_reset),
        .tube_ok(tube_ok), .master_model_fault(master_model_fault),
        .fast_link_fault(fast_link_fault), .multi_link_fault(multi_link_fault),
        .dac_code(dac_code), .dac_sel(dac_sel), .dac_load(dac_load));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Waits a bounded time for one DAC channel, then compares its code.
    task automatic wait_dac(input logic [3:0] sel, input ctm_word_type exp);
        int n;
        for (n = 0; n < 300 && !(dac_load === 1'b1 && dac_sel === sel); n++) @(negedge clock);
        check(32'(n < 300), 32'h1, "dac_found");
        check(32'(dac_code), 32'(exp), "dac_code");
        @(negedge clock);
    endtask
    task automatic load_cfg(input logic [2:0] sel, input logic [31:0] data);
        @(negedge clock);
        cfg = {1'b1, 2'h0, sel, data};
        @(negedge clock);
        cfg.stb = 1'b0;
    endtask
    // Keeps both links alive so the tube flags reflect only the latches.
    task automatic refresh();
        u_link.send_fast(12'h100, 12'h000, 1'b0);
        u_link.send_multi(3'h0, 12'h000, 12'h000, 1'b0);
        repeat (3) @(negedge clock);
    endtask
    task automatic report_and_stop();
        if (errors == 0 && total_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    // A hang counts as a mismatch and ends the run.
    always @(posedge clock) begin
        cycles++;
        if (cycles == 60000) begin
            errors++;
            report_and_stop();
        end
    end
    initial begin
        rst_b = 1'b0;
        fault_reset = 1'b0;
        cfg = '0;
        beam_i = {4{12'h100}};
        fwd_n = '0;
        thr_in = {4{12'h300}};
        repeat (6) @(negedge clock);
        rst_b = 1'b1;
        // Link rows: the flag follows each packet, good packets echo on the DAC.
        foreach (rows[n]) begin
            if (rows[n].multi) u_link.send_multi(3'h0, rows[n].a, rows[n].b, rows[n].bad);
            else u_link.send_fast(rows[n].a, rows[n].b, rows[n].bad);
            @(negedge clock);
            check(rows[n].multi ? multi_link_fault : fast_link_fault, rows[n].bad, "link");
            if (!rows[n].bad && !rows[n].multi) begin
                wait_dac(4'h4, rows[n].a);
                wait_dac(4'h5, rows[n].b);
            end else if (!rows[n].bad) begin
                wait_dac(4'h6, 12'((32'(rows[n].a) * 32'hfff) >> 12));
                wait_dac(4'h7, 12'((32'(rows[n].b) * 32'hfff) >> 12));
            end
        end
        // Model: k1 of 2^24 with V and I of 256 adds 256 counts per step.
        // Sync to a tube 0 load first so the new k1 cannot race a step.
        refresh();
        wait_dac(4'h0, 12'h000);
        load_cfg(3'h4, 32'h0100_0000);
        wait_dac(4'h0, 12'h100);
        m0 = dac_code;
        wait_dac(4'h0, 12'h200);
        m1 = dac_code;
        check(32'(m1 - m0), 32'h100, "model_step");
        repeat (16 * STEP) @(negedge clock);
        refresh();
        check(32'(tube_ok[0]), 32'h0, "trip");
        load_cfg(3'h4, 32'h0000_0000);
        fault_reset = 1'b1;
        repeat (8 * STEP) @(negedge clock);
        refresh();
        check(32'(tube_ok[0]), 32'h0, "still_hot");
        thr_in = {4{12'hfff}};
        repeat (8 * STEP) @(negedge clock);
        refresh();
        check({tube_ok, master_model_fault}, {4'hf, 1'b0}, "cleared");
        fault_reset = 1'b0;
        // A large step must saturate the model code rather than wrap.
        // Tube 0 held 0x600 since k1 went to zero, as every later step added nothing.
        wait_dac(4'h0, 12'h600);
        load_cfg(3'h4, 32'h1000_0000);
        wait_dac(4'h0, 12'hfff);
        // Silence on both links must trip both timeouts.
        repeat (TMO + 50) @(negedge clock);
        check({fast_link_fault, multi_link_fault, tube_ok, master_model_fault}, 7'h61, "tmo");
        // Reset in mid-run returns the documented idle state.
        rst_b = 1'b0;
        @(negedge clock);
        check({tube_ok, master_model_fault, fast_link_fault, multi_link_fault, dac_load}, 8'h0e, "rst");
        rst_b = 1'b1;
        // RF power: N of 256 with c2 of 64 and c4 of 2176 gives 4096 mW.
        // k1 adds 512 and k3 takes 256 per step, all before the first step.
        fwd_n[0] = 12'h100;
        load_cfg(3'h1, 32'h0000_0040);
        load_cfg(3'h3, 32'h0000_0880);
        load_cfg(3'h4, 32'h0200_0000);
        load_cfg(3'h6, 32'h1000_0000);
        refresh();
        wait_dac(4'h0, 12'h100);
        wait_dac(4'h0, 12'h200);
        report_and_stop();
    end
endmodule
